// file: src/rei_defs.vh
// constants for the reset and external interrupt response block
`ifndef REI_DEFS_VH
`define REI_DEFS_VH

// ****************************************
// widths of the pin groups
// ****************************************
`define REI_NUM_INT 4
`define REI_SEL_W 2
`define REI_INUM_W 4
`define REI_DMA_W 4
`define REI_MEM_W 70
`define REI_HOST_W 16
`define REI_SER_W 10

// ****************************************
// interrupt numbering
// ****************************************
// the first external input is reported as this number
`define REI_INUM_BASE 4'h4
`define REI_INUM_IDLE 4'h0

// ****************************************
// timing counts in cpu clock cycles
// ****************************************
`define REI_RESP_MAX 2
`define REI_ACK_LAT 9
`define REI_FETCH_LAT 11
`define REI_HIGH_EXTRA 2
// cycles spent between pin edge and first wait cycle
`define REI_SYNC_DLY 4
`define REI_CNT_W 4

// ****************************************
// sequencer states
// ****************************************
`define REI_ST_IDLE 2'h0
`define REI_ST_WAIT 2'h1
`define REI_ST_ACK 2'h2

`endif

// file: src/rei_core.v
// reset output states and external interrupt acknowledge sequencing
`timescale 1ns/1ps
`include "rei_defs.vh"

// How it works
// [R01] reset pin change answered within two cycles
// [R02] derived clocks stop in reset, restart after
// [R03] low group driven low during reset
// [R04] host ready and interrupt driven high
// [R05] bus, host data, serial pins released
// [R06] source holds interrupt levels two cycles
// [R07] interrupt inputs pass a two-flop synchroniser
// [R08] acknowledge rises at least nine cycles later
// [R09] service fetch starts at least eleven later
// [R10] recognised in high half adds two cycles
// [R11] acknowledge and number change on falling edges
// [R12] reset source holds reset ten cycles minimum
// [R13] number output gives acknowledged index plus four, in binary

module rei_core (
	input wire clk,
	input wire rst,
	input wire resetInN,
	input wire [`REI_NUM_INT-1:0] externalInterruptIn,
	input wire [`REI_DMA_W-1:0] dmaFlagsIn,
	input wire powerDownIn,
	input wire timer0In,
	input wire timer1In,
	input wire hostReadyIn,
	input wire hostInterruptIn,
	input wire [`REI_MEM_W-1:0] memBusIn,
	input wire memBusEnIn,
	input wire [`REI_HOST_W-1:0] hostDataIn,
	input wire hostDataEnIn,
	input wire [`REI_SER_W-1:0] serialPinsIn,
	input wire [`REI_SER_W-1:0] serialPinsEnIn,
	output reg halfRateClockOut,
	output reg sdramClockOut,
	output reg sbsramClockOut,
	output reg interruptAckOut,
	output reg [`REI_INUM_W-1:0] interruptNumberOut,
	output reg serviceFetchOut,
	output reg [`REI_DMA_W-1:0] dmaChannelFlagsOut,
	output reg powerDownOut,
	output reg timer0Out,
	output reg timer1Out,
	output reg hostReadyOut,
	output reg hostInterruptOut,
	output reg [`REI_MEM_W-1:0] memBusOut,
	output reg memBusOe,
	output reg [`REI_HOST_W-1:0] hostDataOut,
	output reg hostDataOe,
	output reg [`REI_SER_W-1:0] serialPinsOut,
	output reg [`REI_SER_W-1:0] serialPinsOe
);

	// ****************************************
	// reset pin capture
	// ****************************************
	reg inReset_ff;

	// rst only covers power-up; the pin is a plain level sampled here
	// one flop of capture, outputs follow on the next edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			inReset_ff <= 1'b1;
		end else begin
			inReset_ff <= ~resetInN; // [R01]
		end
	end

	// ****************************************
	// derived clock outputs
	// ****************************************
	// all three run from one divider so they stay in phase
	// the divider restarts from low, so the first edge out of reset rises
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			halfRateClockOut <= 1'b0;
			sdramClockOut <= 1'b0;
			sbsramClockOut <= 1'b0;
		end else if (inReset_ff) begin
			halfRateClockOut <= 1'b0; // [R02]
			sdramClockOut <= 1'b0; // [R02]
			sbsramClockOut <= 1'b0; // [R02]
		end else begin
			halfRateClockOut <= ~halfRateClockOut; // [R02]
			sdramClockOut <= ~halfRateClockOut;
			sbsramClockOut <= ~halfRateClockOut;
		end
	end

	// next edge is a falling edge of the half-rate clock
	// acknowledge moves only where this is high, which aligns it to falling edges
	wire fallNext;
	assign fallNext = halfRateClockOut;

	// ****************************************
	// output groups under reset
	// ****************************************
	// every group moves on the edge after the pin level is captured
	// low group: forced low in reset, else follows the core
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dmaChannelFlagsOut <= {`REI_DMA_W{1'b0}};
			powerDownOut <= 1'b0;
			timer0Out <= 1'b0;
			timer1Out <= 1'b0;
		end else if (inReset_ff) begin
			dmaChannelFlagsOut <= {`REI_DMA_W{1'b0}}; // [R03]
			powerDownOut <= 1'b0; // [R03]
			timer0Out <= 1'b0; // [R03]
			timer1Out <= 1'b0; // [R03]
		end else begin
			dmaChannelFlagsOut <= dmaFlagsIn;
			powerDownOut <= powerDownIn;
			timer0Out <= timer0In;
			timer1Out <= timer1In;
		end
	end

	// high group: forced high in reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hostReadyOut <= 1'b1;
			hostInterruptOut <= 1'b1;
		end else if (inReset_ff) begin
			hostReadyOut <= 1'b1; // [R04]
			hostInterruptOut <= 1'b1; // [R04]
		end else begin
			hostReadyOut <= hostReadyIn;
			hostInterruptOut <= hostInterruptIn;
		end
	end

	// z group: enables dropped in reset, data held at zero
	// parking the data keeps a later enable from showing stale values
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			memBusOut <= {`REI_MEM_W{1'b0}};
			memBusOe <= 1'b0;
			hostDataOut <= {`REI_HOST_W{1'b0}};
			hostDataOe <= 1'b0;
			serialPinsOut <= {`REI_SER_W{1'b0}};
			serialPinsOe <= {`REI_SER_W{1'b0}};
		end else if (inReset_ff) begin
			memBusOut <= {`REI_MEM_W{1'b0}};
			memBusOe <= 1'b0; // [R05]
			hostDataOut <= {`REI_HOST_W{1'b0}};
			hostDataOe <= 1'b0; // [R05]
			serialPinsOut <= {`REI_SER_W{1'b0}};
			serialPinsOe <= {`REI_SER_W{1'b0}}; // [R05]
		end else begin
			memBusOut <= memBusIn;
			memBusOe <= memBusEnIn;
			hostDataOut <= hostDataIn;
			hostDataOe <= hostDataEnIn;
			serialPinsOut <= serialPinsIn;
			serialPinsOe <= serialPinsEnIn;
		end
	end

	// ****************************************
	// sequencer state codes
	// ****************************************
	localparam [1:0] ST_IDLE = `REI_ST_IDLE;
	localparam [1:0] ST_WAIT = `REI_ST_WAIT;
	localparam [1:0] ST_ACK = `REI_ST_ACK;

	// ****************************************
	// interrupt synchronisers and pending flags
	// ****************************************
	reg [`REI_NUM_INT-1:0] syncA_ff;
	reg [`REI_NUM_INT-1:0] syncB_ff;
	reg [`REI_NUM_INT-1:0] syncC_ff;
	reg [`REI_NUM_INT-1:0] pend_ff;
	wire [`REI_NUM_INT-1:0] rise;
	wire [`REI_NUM_INT-1:0] clrPend;
	reg [1:0] state_ff;
	reg [`REI_SEL_W-1:0] sel_ff;
	reg [`REI_SEL_W-1:0] pick;
	wire anyPend;
	wire take;

	assign anyPend = |pend_ff;
	assign take = (state_ff == ST_IDLE) && anyPend && !inReset_ff;

	genvar gi;
	generate
		for (gi = 0; gi < `REI_NUM_INT; gi = gi + 1) begin : gInt
			// first stage only feeds the second; edge seen after it
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					syncA_ff[gi] <= 1'b0;
					syncB_ff[gi] <= 1'b0;
					syncC_ff[gi] <= 1'b0;
				end else begin
					syncA_ff[gi] <= externalInterruptIn[gi]; // [R07]
					syncB_ff[gi] <= syncA_ff[gi]; // [R07]
					syncC_ff[gi] <= syncB_ff[gi];
				end
			end
			// third stage keeps the last level, so one edge gives one pulse
			assign rise[gi] = syncB_ff[gi] & ~syncC_ff[gi];
			assign clrPend[gi] = take && (pick == gi);
			// a new edge in the clearing cycle keeps the flag set
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					pend_ff[gi] <= 1'b0;
				end else if (inReset_ff) begin
					pend_ff[gi] <= 1'b0;
				end else begin
					pend_ff[gi] <= rise[gi] | (pend_ff[gi] & ~clrPend[gi]);
				end
			end
		end
	endgenerate

	// lowest index wins among pending inputs
	// a pin that loses stays pending and is served after the current one
	integer k;
	always @* begin
		pick = {`REI_SEL_W{1'b0}};
		for (k = `REI_NUM_INT - 1; k >= 0; k = k - 1) begin
			if (pend_ff[k]) begin
				pick = k[`REI_SEL_W-1:0];
			end
		end
	end

	// ****************************************
	// acknowledge sequencer
	// ****************************************
	// cnt_ff holds the wait cycles left before edge alignment
	reg [`REI_CNT_W-1:0] cnt_ff;
	wire [`REI_CNT_W-1:0] baseLoad;
	wire [`REI_CNT_W-1:0] extraLoad;

	// wait counts worked out at full width, then cut to the counter
	localparam integer BASE_WAIT = `REI_ACK_LAT - `REI_SYNC_DLY;
	localparam integer EXTRA_WAIT = `REI_HIGH_EXTRA;

	// synchroniser and pending flag already spend part of the latency
	assign baseLoad = BASE_WAIT[`REI_CNT_W-1:0]; // [R08]
	assign extraLoad = EXTRA_WAIT[`REI_CNT_W-1:0]; // [R10]

	// wait, then raise acknowledge on a falling half-rate edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			cnt_ff <= {`REI_CNT_W{1'b0}};
			sel_ff <= {`REI_SEL_W{1'b0}};
			interruptAckOut <= 1'b0;
			interruptNumberOut <= `REI_INUM_IDLE;
			serviceFetchOut <= 1'b0;
		end else if (inReset_ff) begin
			// a pin reset in mid-sequence drops the request in flight
			state_ff <= ST_IDLE;
			cnt_ff <= {`REI_CNT_W{1'b0}};
			interruptAckOut <= 1'b0; // [R03]
			interruptNumberOut <= `REI_INUM_IDLE; // [R03]
			serviceFetchOut <= 1'b0;
		end else begin
			serviceFetchOut <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					if (take) begin
						sel_ff <= pick;
						// high half of the half-rate clock costs two more
						if (halfRateClockOut) begin
							cnt_ff <= baseLoad + extraLoad; // [R10]
						end else begin
							cnt_ff <= baseLoad; // [R08]
						end
						state_ff <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// count out the wait, then hold for a falling half-rate edge
					if (cnt_ff != {`REI_CNT_W{1'b0}}) begin
						cnt_ff <= cnt_ff - 1'b1;
					end else if (fallNext) begin
						interruptAckOut <= 1'b1; // [R11]
						interruptNumberOut <= `REI_INUM_BASE + {2'b00, sel_ff}; // [R13]
						state_ff <= ST_ACK;
					end
				end
				ST_ACK: begin
					// acknowledge lasts one half-rate period
					if (fallNext) begin
						interruptAckOut <= 1'b0; // [R11]
						interruptNumberOut <= `REI_INUM_IDLE;
						// fetch pulse marks the start of the service fetch
						serviceFetchOut <= 1'b1; // [R09]
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// file: tb/rei_core_monitor.sv
// checker of reset levels and interrupt acknowledge timing
`timescale 1ns/1ps
`include "rei_defs.vh"
module rei_core_monitor (
	input wire clk,
	input wire rst,
	input wire resetInN,
	input wire [`REI_NUM_INT-1:0] externalInterruptIn,
	input wire halfRateClockOut,
	input wire interruptAckOut,
	input wire [`REI_INUM_W-1:0] interruptNumberOut,
	input wire serviceFetchOut,
	input wire [`REI_DMA_W-1:0] dmaChannelFlagsOut,
	input wire hostReadyOut,
	input wire memBusOe
);
	// ****
	// properties
	// ****
	reg [5:0] age_ff [0:3];
	reg [3:0] prev_ff;
	integer i;
	// cycles since each pin rose, saturating
	always @(posedge clk) begin
		prev_ff <= externalInterruptIn;
		for (i = 0; i < 4; i = i + 1) begin
			if (externalInterruptIn[i] && !prev_ff[i]) begin
				age_ff[i] <= 6'h00;
			end else if (age_ff[i] != 6'h3f) begin
				age_ff[i] <= age_ff[i] + 6'h01;
			end
		end
	end
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_low;
		!resetInN [*3] |-> !{dmaChannelFlagsOut, interruptAckOut, interruptNumberOut};
	endproperty
	a_low: assert property (p_low) else $error("low group set");
	property p_high;
		!resetInN [*3] |-> hostReadyOut;
	endproperty
	a_high: assert property (p_high) else $error("high group low");
	property p_zgrp;
		!resetInN [*3] |-> !memBusOe;
	endproperty
	a_zgrp: assert property (p_zgrp) else $error("bus driven");
	property p_stop;
		!resetInN [*3] |-> !halfRateClockOut;
	endproperty
	a_stop: assert property (p_stop) else $error("clock runs");
	property p_run;
		resetInN [*3] |-> halfRateClockOut != $past(halfRateClockOut);
	endproperty
	a_run: assert property (p_run) else $error("clock stuck");
	property p_age;
		$rose(interruptAckOut) |-> age_ff[interruptNumberOut[1:0]] >= 6'h09;
	endproperty
	a_age: assert property (p_age) else $error("ack early");
	property p_edge;
		resetInN [*4] ##0 $changed({interruptAckOut, interruptNumberOut}) |-> $fell(halfRateClockOut);
	endproperty
	a_edge: assert property (p_edge) else $error("ack off edge");
	property p_pulse;
		$rose(interruptAckOut) |-> interruptNumberOut[3:2] == 2'h1 ##1
			interruptAckOut && $stable(interruptNumberOut) ##1 serviceFetchOut && !interruptAckOut;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ack pulse");
endmodule

bind rei_core rei_core_monitor rei_core_monitor_i (.clk, .rst, .resetInN, .externalInterruptIn,
	.halfRateClockOut, .interruptAckOut, .interruptNumberOut, .serviceFetchOut,
	.dmaChannelFlagsOut, .hostReadyOut, .memBusOe);

// file: tb/rei_pin_source.sv
// board reset source and interrupt sources
`timescale 1ns/1ps
`include "rei_defs.vh"
module rei_pin_source (
	input wire clk,
	output reg resetInN,
	output reg [`REI_NUM_INT-1:0] externalInterruptIn
);
	// power up in reset, pins quiet
	initial begin
		resetInN = 1'b0;
		externalInterruptIn = 4'h0;
	end
	// reset low at least ten cycles
	task holdReset(input integer n);
		begin
			@(negedge clk);
			resetInN = 1'b0;
			repeat ((n < 10) ? 10 : n) @(negedge clk);
			resetInN = 1'b1;
		end
	endtask
	// several pins high together for n cycles, then low two
	task pulseMask(input [`REI_NUM_INT-1:0] m, input integer n);
		begin
			@(negedge clk);
			externalInterruptIn = m;
			repeat ((n < 2) ? 2 : n) @(negedge clk);
			externalInterruptIn = {`REI_NUM_INT{1'b0}};
			repeat (2) @(negedge clk);
		end
	endtask
	// pin high n cycles, then low two
	task pulse(input integer idx, input integer n);
		begin
			@(negedge clk);
			externalInterruptIn[idx] = 1'b1;
			repeat ((n < 2) ? 2 : n) @(negedge clk);
			externalInterruptIn[idx] = 1'b0;
			repeat (2) @(negedge clk);
		end
	endtask
endmodule

// file: tb/rei_core_tb_top.sv
// self-checking bench for reset levels and interrupt acknowledge
`timescale 1ns/1ps
`include "rei_defs.vh"
`define REI_CHK(got, exp) begin \
	comparisons = comparisons + 1; \
	if ((got) !== (exp)) begin \
		fails = fails + 1; \
		$display("Error %0t mismatch", $time); \
	end \
end
module rei_core_tb_top;
	reg clk, rst, powerDownIn, timer0In, timer1In, hostReadyIn, hostInterruptIn;
	reg memBusEnIn, hostDataEnIn;
	reg [`REI_DMA_W-1:0] dmaFlagsIn;
	reg [`REI_SER_W-1:0] serialPinsEnIn;
	wire resetInN, halfRateClockOut, sdramClockOut, sbsramClockOut, interruptAckOut;
	wire serviceFetchOut, powerDownOut, timer0Out, timer1Out, hostReadyOut, hostInterruptOut;
	wire memBusOe, hostDataOe;
	wire [`REI_NUM_INT-1:0] externalInterruptIn;
	wire [`REI_INUM_W-1:0] interruptNumberOut;
	wire [`REI_DMA_W-1:0] dmaChannelFlagsOut;
	wire [`REI_SER_W-1:0] serialPinsOe;
	wire [`REI_MEM_W-1:0] memBusOut;
	wire [`REI_HOST_W-1:0] hostDataOut;
	wire [`REI_SER_W-1:0] serialPinsOut;
	integer fails, comparisons, k;
	rei_pin_source rei_pin_source_i (.clk, .resetInN, .externalInterruptIn);
	rei_core rei_core_i (.clk, .rst, .resetInN, .externalInterruptIn, .dmaFlagsIn, .powerDownIn,
		.timer0In, .timer1In, .hostReadyIn, .hostInterruptIn, .memBusIn({`REI_MEM_W{1'b1}}),
		.memBusEnIn, .hostDataIn(16'hffff), .hostDataEnIn, .serialPinsIn(10'h3ff),
		.serialPinsEnIn, .halfRateClockOut, .sdramClockOut, .sbsramClockOut, .interruptAckOut,
		.interruptNumberOut, .serviceFetchOut, .dmaChannelFlagsOut, .powerDownOut, .timer0Out,
		.timer1Out, .hostReadyOut, .hostInterruptOut, .memBusOut, .memBusOe, .hostDataOut,
		.hostDataOe, .serialPinsOut, .serialPinsOe);
	// ****
	// scenarios
	// ****
	// cpu clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// verdict and end of run
	task summarize;
		begin
			if (fails == 0 && comparisons > 0) begin
				$display("== PASSED ==");
			end else begin
				$display("== FAILED ==");
			end
			$finish;
		end
	endtask
	// reset entry levels, then release and resumed copies
	task t_rst;
		reg h;
		begin
			fork
				rei_pin_source_i.holdReset(12);
				begin
					// two cycles after the pin falls every group holds its reset state
					repeat (3) @(negedge clk);
					`REI_CHK({dmaChannelFlagsOut, powerDownOut, timer0Out, timer1Out}, 7'h00)
					`REI_CHK({hostReadyOut, hostInterruptOut}, 2'h3)
					`REI_CHK({memBusOe, hostDataOe, serialPinsOe}, 12'h000)
					`REI_CHK({memBusOut, hostDataOut, serialPinsOut}, 96'h0)
					`REI_CHK({halfRateClockOut, sdramClockOut, sbsramClockOut}, 3'h0)
				end
			join
			// two cycles after the pin rises every group follows the core
			repeat (2) @(negedge clk);
			`REI_CHK({dmaChannelFlagsOut, powerDownOut, timer0Out, timer1Out}, 7'h7f)
			`REI_CHK({hostReadyOut, hostInterruptOut, memBusOe, hostDataOe}, 4'h3)
			`REI_CHK(serialPinsOe, serialPinsEnIn)
			`REI_CHK({memBusOut, hostDataOut, serialPinsOut}, {96{1'b1}})
			h = halfRateClockOut;
			@(negedge clk);
			`REI_CHK({halfRateClockOut, sdramClockOut, sbsramClockOut}, {3{~h}})
		end
	endtask
	// one pin raised: ack latency, number, fetch pulse
	task t_int(input integer idx);
		integer n;
		reg hi;
		begin
			n = 0;
			hi = 1'b0;
			fork
				rei_pin_source_i.pulse(idx, 20);
				begin
					@(negedge clk);
					while (interruptAckOut !== 1'b1 && n < 20) begin
						@(negedge clk);
						n = n + 1;
						// half-rate level standing at the edge that takes the request
						if (n == 3) begin
							hi = halfRateClockOut;
						end
					end
					`REI_CHK(n >= (hi ? 12 : 10) && n <= (hi ? 13 : 11), 1'b1)
					`REI_CHK(interruptNumberOut, `REI_INUM_BASE + idx[3:0])
					repeat (2) @(negedge clk);
					`REI_CHK({interruptAckOut, serviceFetchOut, interruptNumberOut}, 6'h10)
				end
			join
		end
	endtask
	// two pins together: lower index served first, the other kept pending
	task t_two;
		integer n;
		begin
			n = 0;
			fork
				rei_pin_source_i.pulseMask(4'h6, 20);
				begin
					while (interruptAckOut !== 1'b1 && n < 40) begin
						@(negedge clk);
						n = n + 1;
					end
					`REI_CHK(interruptNumberOut, `REI_INUM_BASE + 4'h1)
					while (interruptAckOut !== 1'b0 && n < 40) begin
						@(negedge clk);
						n = n + 1;
					end
					while (interruptAckOut !== 1'b1 && n < 40) begin
						@(negedge clk);
						n = n + 1;
					end
					`REI_CHK(interruptNumberOut, `REI_INUM_BASE + 4'h2)
				end
			join
		end
	endtask
	// hang guard
	initial begin
		#4000;
		fails = fails + 1;
		summarize;
	end
	// main sequence; each pulse spans an odd count so the phase alternates
	initial begin
		fails = 0;
		comparisons = 0;
		rst = 1'b1;
		{dmaFlagsIn, powerDownIn, timer0In, timer1In} = 7'h7f;
		{hostReadyIn, hostInterruptIn, memBusEnIn, hostDataEnIn} = 4'h3;
		serialPinsEnIn = 10'h2a5;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_rst;
		for (k = 0; k < 4; k = k + 1) begin
			t_int(k);
		end
		t_two;
		t_rst;
		summarize;
	end
endmodule
